/* File: shared/led_seq_pkg.sv */
// Notes on behaviour
// R1 - Host pulses device reset before any operation.
// R2 - Host loads all settings before relying on feedback.
// R3 - Once loaded, device samples sensor against target.
// R4 - Error trims each colour duty factor.
// R5 - Each duty factor is twelve bits.
// R6 - Host may read out and restore registers itself.
// R7 - Upload command copies registers to memory.
// R8 - Download command fetches registers, then normal mode.
// R9 - Memory master addresses device 0x50 fixed protocol.
// R10 - Standalone strap: self download, then drive target.
// R11 - Open-loop mode stops feedback trimming.
// R12 - Search command: LEDs full, sensitivity searched.
// R13 - Host writes camera values; sample stores sensor.
// R14 - Calc command derives sensor-to-camera mapping.
// R15 - Active-low reset clears all device registers.
// R16 - Sleep freezes core and powers analog down.
// R17 - PWM period is (setting plus one) times 4096.
// R18 - LED outputs stay low until feedback starts; the search command also drives them.
package led_seq_pkg;
    localparam int CLK_HZ          = 40_000_000;
    localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
    localparam int RESET_PULSE_NS  = 10_000;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int MEM_BIT_NS      = 10_000;
    localparam int QUARTER_CYC     = (MEM_BIT_NS * CLK_MHZ + 3999) / 4000;
    localparam int QCNT_W          = 7;
    localparam int RCNT_W          = 9;
    localparam int DUTY_W          = 12;
    localparam int NREG            = 16;
    localparam logic [6:0] MEM_DEV_ADDR = 7'h50;
    localparam logic [7:0] MEM_WR_BYTE  = {MEM_DEV_ADDR, 1'b0};
    localparam logic [7:0] MEM_RD_BYTE  = {MEM_DEV_ADDR, 1'b1};
    localparam logic [7:0] MEM_WORD0    = 8'h00;
    // Device register indices.
    localparam int REG_PERIOD = 0;
    localparam int REG_MODE   = 1;
    localparam int REG_TARGET = 2;
    localparam int REG_CAMERA = 5;
    localparam int REG_SENSOR = 8;
    localparam int REG_OFFSET = 11;
    localparam int REG_SENS   = 14;
    localparam int REG_STATUS = 15;
    localparam int MODE_OPEN_LOOP_BIT = 0;
    localparam logic [7:0]        REG_RESET  = 8'h00;
    localparam logic [DUTY_W-1:0] DUTY_RESET = 12'h000;
    localparam logic [DUTY_W-1:0] DUTY_MAX   = 12'hfff;
    localparam logic [7:0]        SENS_START = 8'hff;
    localparam logic [DUTY_W-1:0] SAT_LEVEL  = 12'he00;
    // Host Avalon map and fields.
    localparam logic [3:0] AV_CTRL   = 4'h0;
    localparam logic [3:0] AV_CMD    = 4'h4;
    localparam logic [3:0] AV_STATUS = 4'h8;
    localparam logic [3:0] AV_RDATA  = 4'hc;
    localparam int CTRL_RESET_BIT  = 0;
    localparam int CTRL_SLEEP_BIT  = 1;
    localparam int CMD_DATA_LSB    = 0;
    localparam int CMD_ADDR_LSB    = 8;
    localparam int CMD_CODE_LSB    = 12;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DONE_BIT   = 1;
    localparam int STAT_LRST_BIT   = 2;

    typedef enum logic [2:0] {
        CMD_WRITE, CMD_READ, CMD_UPLOAD, CMD_DOWNLOAD,
        CMD_RUN, CMD_SEARCH, CMD_SAMPLE, CMD_CALC
    } cmd_t;
endpackage

/* File: shared/led_link_if.sv */
`timescale 1ns/10ps
interface led_link_if;
    logic                    hw_reset_n;
    logic                    sleep;
    logic                    cmd_valid;
    led_seq_pkg::cmd_t       cmd_code;
    logic [3:0]              cmd_addr;
    logic [7:0]              cmd_wdata;
    logic                    cmd_ready;
    logic                    rsp_valid;
    logic [7:0]              rsp_data;

    modport dev (input hw_reset_n, sleep, cmd_valid, cmd_code, cmd_addr, cmd_wdata,
                 output cmd_ready, rsp_valid, rsp_data);
    modport host (output hw_reset_n, sleep, cmd_valid, cmd_code, cmd_addr, cmd_wdata,
                  input cmd_ready, rsp_valid, rsp_data);
endinterface

/* File: rtl/led_seq_device.sv */
`timescale 1ns/10ps
module led_seq_device (
    input  wire logic                        CLK_IN,
    input  wire logic                        RESET_IN,
    input  wire logic                        CE_IN,
    input  wire logic                        STANDALONE_IN,
    input  wire logic [led_seq_pkg::DUTY_W-1:0] SENSOR_RED_IN,
    input  wire logic [led_seq_pkg::DUTY_W-1:0] SENSOR_GREEN_IN,
    input  wire logic [led_seq_pkg::DUTY_W-1:0] SENSOR_BLUE_IN,
    input  wire logic                        MEMORY_PORT_DATA_IN,
    output logic                             MEMORY_PORT_CLOCK_OUT,
    output logic                             MEMORY_PORT_DATA_OUT,
    output logic                             MEMORY_PORT_DATA_OE_OUT,
    output logic                             RED_LED_DRIVE_OUT,
    output logic                             GREEN_LED_DRIVE_OUT,
    output logic                             BLUE_LED_DRIVE_OUT,
    output logic [7:0]                       SENSITIVITY_OUT,
    output logic                             ANALOG_POWER_DOWN_OUT,
    led_link_if.dev                          link
);
    import led_seq_pkg::*;

    typedef enum logic [1:0] {S_READY, S_MEM, S_SEARCH} dstate_t;
    typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;

    typedef struct packed {
        dstate_t                      st;
        mstate_t                      ms;
        logic                         boot;
        logic                         run;
        logic                         upload;
        logic [1:0]                   ph;
        logic [QCNT_W-1:0]            qcnt;
        logic [4:0]                   bi;
        logic [3:0]                   bitn;
        logic [7:0]                   sh;
        logic                         scl;
        logic                         sda_oe;
        logic [NREG-1:0][7:0]         regs;
        logic [2:0][DUTY_W-1:0]       duty;
        logic [7:0]                   pre;
        logic [DUTY_W-1:0]            pcnt;
        logic [2:0]                   pwm;
        logic                         rsp_v;
        logic [7:0]                   rsp_d;
    } dev_t;

    localparam dev_t DEV_RST = '{st: S_READY, ms: M_IDLE, boot: 1'b1, scl: 1'b1, default: '0};

    dev_t                       s;
    dev_t                       n;
    logic [2:0][DUTY_W-1:0]     sensor;
    logic                       wrap;
    logic                       led_on;
    logic                       rx;
    logic                       any_sat;
    logic [7:0]                 status;

    // One step toward the target per sample; saturation avoids wrap-around flicker.
    function automatic logic [DUTY_W-1:0] trim(input logic [DUTY_W-1:0] d,
                                               input logic [7:0] meas,
                                               input logic [7:0] tgt);
        logic [DUTY_W-1:0] r;
        r = d;
        if (meas < tgt && d != DUTY_MAX) begin
            r = d + 12'h001;
        end else if (meas > tgt && d != DUTY_RESET) begin
            r = d - 12'h001;
        end
        return r;
    endfunction

    assign sensor = {SENSOR_BLUE_IN, SENSOR_GREEN_IN, SENSOR_RED_IN};
    assign status = {5'h00, s.st == S_SEARCH, s.st == S_MEM, s.run};
    assign rx     = !s.upload && s.bi >= 5'd3;
    assign link.cmd_ready = (s.st == S_READY) && !s.boot && CE_IN && !link.sleep;

    always_comb begin
        n = s;
        n.rsp_v = 1'b0;
        wrap = 1'b0;
        any_sat = 1'b0;
        // Each duty step lasts period setting plus one clocks, over 4096 steps.
        if (s.pre == s.regs[REG_PERIOD]) begin // [R17]
            n.pre = 8'h00;
            n.pcnt = s.pcnt + 12'h001;
            wrap = (s.pcnt == DUTY_MAX);
        end else begin
            n.pre = s.pre + 8'h01;
        end
        led_on = s.run || s.st == S_SEARCH;
        for (int c = 0; c < 3; c++) begin
            n.pwm[c] = led_on && (s.pcnt < s.duty[c]); // [R5] [R18]
            any_sat = any_sat || (sensor[c] >= SAT_LEVEL);
        end
        // Sensor is sampled once per PWM period, so every reading spans whole cycles.
        if (wrap && s.run && s.st != S_SEARCH && !s.regs[REG_MODE][MODE_OPEN_LOOP_BIT]) begin // [R3] [R11]
            for (int c = 0; c < 3; c++) begin
                n.duty[c] = trim(s.duty[c], sensor[c][11:4] + s.regs[REG_OFFSET+c],
                                 s.regs[REG_TARGET+c]); // [R4]
            end
        end
        unique case (s.st)
            S_READY: begin
                if (s.boot) begin
                    n.boot = 1'b0;
                    if (STANDALONE_IN) begin // [R10]
                        n.st = S_MEM;
                        n.upload = 1'b0;
                        n.ms = M_START;
                        n.bi = 5'd0;
                        n.ph = 2'd0;
                        n.qcnt = '0;
                        n.sh = MEM_WR_BYTE;
                    end
                end else if (link.cmd_valid) begin
                    n.rsp_v = 1'b1;
                    n.rsp_d = status;
                    unique case (link.cmd_code)
                        CMD_WRITE: begin
                            if (link.cmd_addr != 4'(REG_STATUS)) begin
                                n.regs[link.cmd_addr] = link.cmd_wdata; // [R6] [R13]
                            end
                        end
                        CMD_READ: begin
                            n.rsp_d = (link.cmd_addr == 4'(REG_STATUS)) ? status : s.regs[link.cmd_addr]; // [R6]
                        end
                        CMD_UPLOAD, CMD_DOWNLOAD: begin // [R7] [R8]
                            n.rsp_v = 1'b0;
                            n.st = S_MEM;
                            n.upload = (link.cmd_code == CMD_UPLOAD);
                            n.ms = M_START;
                            n.bi = 5'd0;
                            n.ph = 2'd0;
                            n.qcnt = '0;
                            n.sh = MEM_WR_BYTE;
                        end
                        CMD_RUN: begin
                            n.run = 1'b1; // [R3]
                            n.rsp_d[0] = 1'b1;
                        end
                        CMD_SEARCH: begin // [R12]
                            n.rsp_v = 1'b0;
                            n.st = S_SEARCH;
                            n.regs[REG_SENS] = SENS_START;
                            n.duty = {3{DUTY_MAX}};
                        end
                        CMD_SAMPLE: begin
                            n.regs[REG_SENSOR+int'(link.cmd_wdata[1:0])] =
                                sensor[link.cmd_wdata[1:0]][11:4]; // [R13]
                        end
                        CMD_CALC: begin
                            for (int c = 0; c < 3; c++) begin
                                n.regs[REG_OFFSET+c] = s.regs[REG_CAMERA+c] - s.regs[REG_SENSOR+c]; // [R14]
                            end
                        end
                    endcase
                end
            end
            S_SEARCH: begin
                // Highest sensitivity that keeps every channel below saturation wins.
                if (wrap) begin
                    if (any_sat && s.regs[REG_SENS] != 8'h00) begin
                        n.regs[REG_SENS] = s.regs[REG_SENS] - 8'h01; // [R12]
                    end else begin
                        n.st = S_READY;
                        n.rsp_v = 1'b1;
                        n.rsp_d = status;
                    end
                end
            end
            S_MEM: begin
                if (s.qcnt == QCNT_W'(QUARTER_CYC - 1)) begin
                    n.qcnt = '0;
                    n.ph = s.ph + 2'd1;
                    unique case (s.ms)
                        M_START: begin
                            unique case (s.ph)
                                2'd0: n.sda_oe = 1'b0;
                                2'd1: n.scl = 1'b1;
                                2'd2: n.sda_oe = 1'b1;
                                2'd3: begin
                                    n.scl = 1'b0;
                                    n.ms = M_BIT;
                                    n.bitn = 4'd0;
                                end
                            endcase
                        end
                        M_BIT: begin
                            unique case (s.ph)
                                2'd0: begin
                                    if (s.bitn == 4'd8) begin
                                        n.sda_oe = rx && (s.bi != 5'(NREG + 2));
                                    end else begin
                                        n.sda_oe = !rx && !s.sh[7];
                                    end
                                end
                                2'd1: n.scl = 1'b1;
                                2'd2: begin
                                    if (rx && s.bitn != 4'd8) begin
                                        n.sh = {s.sh[6:0], MEMORY_PORT_DATA_IN};
                                    end
                                end
                                2'd3: begin
                                    n.scl = 1'b0;
                                    n.bitn = s.bitn + 4'd1;
                                    if (!rx && s.bitn != 4'd8) begin
                                        n.sh = {s.sh[6:0], 1'b0};
                                    end
                                    if (s.bitn == 4'd8) begin
                                        n.bi = s.bi + 5'd1;
                                        n.bitn = 4'd0;
                                        if (rx) begin
                                            n.regs[4'(s.bi - 5'd3)] = s.sh; // [R8]
                                        end
                                        if (s.upload) begin
                                            n.sh = (s.bi == 5'd0) ? MEM_WORD0 : s.regs[4'(s.bi - 5'd1)]; // [R7]
                                            if (s.bi == 5'(NREG + 1)) begin
                                                n.ms = M_STOP;
                                            end
                                        end else if (s.bi == 5'd0) begin
                                            n.sh = MEM_WORD0;
                                        end else if (s.bi == 5'd1) begin
                                            n.ms = M_START;
                                            n.sh = MEM_RD_BYTE; // [R9]
                                        end else if (s.bi == 5'(NREG + 2)) begin
                                            n.ms = M_STOP;
                                        end
                                    end
                                end
                            endcase
                        end
                        M_STOP: begin
                            unique case (s.ph)
                                2'd0: n.sda_oe = 1'b1;
                                2'd1: n.scl = 1'b1;
                                2'd2: n.sda_oe = 1'b0;
                                2'd3: begin
                                    n.ms = M_IDLE;
                                    n.st = S_READY;
                                    n.run = s.run || !s.upload; // [R8] [R10]
                                    n.rsp_v = 1'b1;
                                    n.rsp_d = {7'h00, n.run};
                                end
                            endcase
                        end
                    endcase
                end else begin
                    n.qcnt = s.qcnt + QCNT_W'(1);
                end
            end
            default: n.st = S_READY;
        endcase
    end

    // Sleep is treated as a clock gate: nothing advances while it is high.
    always_ff @(posedge CLK_IN or negedge link.hw_reset_n) begin
        if (!link.hw_reset_n) begin
            s <= DEV_RST; // [R15]
        end else if (RESET_IN) begin
            s <= DEV_RST;
        end else if (CE_IN && !link.sleep) begin // [R16]
            s <= n;
        end
    end

    assign MEMORY_PORT_CLOCK_OUT   = s.scl;
    assign MEMORY_PORT_DATA_OUT    = 1'b0;
    assign MEMORY_PORT_DATA_OE_OUT = s.sda_oe;
    assign RED_LED_DRIVE_OUT       = s.pwm[0];
    assign GREEN_LED_DRIVE_OUT     = s.pwm[1];
    assign BLUE_LED_DRIVE_OUT      = s.pwm[2];
    assign SENSITIVITY_OUT         = s.regs[REG_SENS];
    assign ANALOG_POWER_DOWN_OUT   = link.sleep; // [R16]
    assign link.rsp_valid          = s.rsp_v;
    assign link.rsp_data           = s.rsp_d;
endmodule

/* File: rtl/led_seq_host.sv */
`timescale 1ns/10ps
module led_seq_host (
    input  wire logic        CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        CE_IN,
    input  wire logic [3:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0]      AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    led_link_if.host         link
);
    import led_seq_pkg::*;

    typedef struct packed {
        logic              cmd_v;
        cmd_t              code;
        logic [3:0]        addr;
        logic [7:0]        wdata;
        logic              busy;
        logic              done;
        logic [7:0]        rdata;
        logic [RCNT_W-1:0] rcnt;
        logic              hwn;
        logic              sleep;
        logic              rd_ack;
        logic [31:0]       rdd;
    } host_t;

    localparam host_t HOST_RST = '{code: CMD_WRITE, rcnt: RCNT_W'(RESET_PULSE_CYC), default: '0};

    host_t s;
    host_t n;
    logic  cmd_wr;

    assign cmd_wr = AVS_WRITE_IN && AVS_ADDRESS_IN == AV_CMD;
    // A command write stalls while one is in flight or the device is held in reset.
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN && !s.rd_ack) || (cmd_wr && (s.busy || !s.hwn));

    always_comb begin
        n = s;
        n.rd_ack = 1'b0;
        if (s.rcnt != '0) begin
            n.rcnt = s.rcnt - RCNT_W'(1); // [R1]
        end
        if (AVS_READ_IN && !s.rd_ack) begin
            n.rd_ack = 1'b1;
            unique case (AVS_ADDRESS_IN)
                AV_CTRL:   n.rdd = {30'h0, s.sleep, !s.hwn};
                AV_STATUS: n.rdd = {29'h0, !s.hwn, s.done, s.busy};
                AV_RDATA:  n.rdd = {24'h0, s.rdata};
                default:   n.rdd = 32'h0;
            endcase
        end
        if (AVS_WRITE_IN && AVS_ADDRESS_IN == AV_CTRL) begin
            n.sleep = AVS_WRITEDATA_IN[CTRL_SLEEP_BIT];
            if (AVS_WRITEDATA_IN[CTRL_RESET_BIT]) begin
                n.rcnt = RCNT_W'(RESET_PULSE_CYC); // [R1]
                n.cmd_v = 1'b0;
                n.busy = 1'b0;
            end
        end
        if (cmd_wr && !s.busy && s.hwn) begin
            n.code = cmd_t'(AVS_WRITEDATA_IN[CMD_CODE_LSB +: 3]);
            n.addr = AVS_WRITEDATA_IN[CMD_ADDR_LSB +: 4];
            n.wdata = AVS_WRITEDATA_IN[CMD_DATA_LSB +: 8];
            n.cmd_v = 1'b1;
            n.busy = 1'b1;
            n.done = 1'b0;
        end
        if (s.cmd_v && link.cmd_ready) begin
            n.cmd_v = 1'b0;
        end
        if (s.busy && link.rsp_valid) begin
            n.busy = 1'b0;
            n.done = 1'b1;
            n.rdata = link.rsp_data; // [R6]
        end
        n.hwn = (n.rcnt == '0);
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            s <= HOST_RST;
        end else if (CE_IN) begin
            s <= n;
        end
    end

    assign AVS_READDATA_OUT = s.rdd;
    assign link.hw_reset_n  = s.hwn;
    assign link.sleep       = s.sleep;
    assign link.cmd_valid   = s.cmd_v;
    assign link.cmd_code    = s.code;
    assign link.cmd_addr    = s.addr;
    assign link.cmd_wdata   = s.wdata;
endmodule

/* File: tb/led_seq_link_assertions.sv */
`timescale 1ns/10ps
module led_seq_link_assertions (
    input wire logic              CLK_IN,
    input wire logic              RESET_IN,
    input wire logic              hw_reset_n,
    input wire logic              sleep,
    input wire logic              cmd_valid,
    input wire led_seq_pkg::cmd_t cmd_code,
    input wire logic [3:0]        cmd_addr,
    input wire logic [7:0]        cmd_wdata,
    input wire logic              cmd_ready,
    input wire logic              rsp_valid,
    input wire logic [7:0]        rsp_data
);
    import led_seq_pkg::*;
    // Sleep freezes the device, so a handshake seen while asleep is not a real take.
    wire logic take = cmd_valid && cmd_ready && !sleep;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN || !hw_reset_n);
    AST_RSP_NEXT:
        assert property (take && cmd_code inside {CMD_WRITE, CMD_READ, CMD_SAMPLE, CMD_CALC} |=> rsp_valid)
        else $error("short command not answered next cycle");
    AST_RUN_STATUS:
        assert property (take && cmd_code == CMD_RUN |=> rsp_valid && rsp_data[0])
        else $error("run command did not report normal mode");
    AST_RSP_PULSE:
        assert property (rsp_valid && !sleep |=> !rsp_valid)
        else $error("completion longer than one cycle");
    AST_HOLD_REQ:
        assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code) && $stable(cmd_addr)
                         && $stable(cmd_wdata))
        else $error("pending command changed before it was taken");
    AST_RELEASE:
        assert property (take |=> !cmd_valid)
        else $error("command held after it was taken");
    AST_RESET_READY:
        assert property (disable iff (RESET_IN) !hw_reset_n |-> !cmd_ready)
        else $error("device ready while held in reset");
    AST_BOOT_CYCLE:
        assert property ($rose(hw_reset_n) |-> !cmd_ready)
        else $error("device ready in its boot cycle");
    AST_SLEEP_FREEZE:
        assert property (sleep && !rsp_valid |=> !rsp_valid)
        else $error("completion raised while asleep");
    cover property (take && cmd_code == CMD_DOWNLOAD);
    cover property (take && cmd_code == CMD_SAMPLE);
    cover property ($rose(sleep));
endmodule

/* File: tb/led_color_feedback_sequencer_tb.sv */
`timescale 1ns/10ps
module led_color_feedback_sequencer_tb;
    import led_seq_pkg::*;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [3:0]  av_addr = 4'h0;
    logic        av_read = 1'b0;
    logic        av_write = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic        strap = 1'b0;
    logic [11:0] sns [3] = '{12'h000, 12'h000, 12'h000};
    logic [7:0]  cam [3];
    logic        scl, sda_oe, red, green, blue, apd;
    logic [7:0]  sens_set, shf;
    wire logic   sda_w = !sda_oe;
    logic [7:0]  mem_q [$];
    int          bitn = 9;
    int          errors = 0;
    int          checks = 0;
    led_link_if link ();
    led_seq_host i_led_seq_host (.CLK_IN(clk_in), .RESET_IN(reset_in), .CE_IN(1'b1), .AVS_ADDRESS_IN(av_addr),
        .AVS_READ_IN(av_read), .AVS_WRITE_IN(av_write), .AVS_WRITEDATA_IN(av_wdata),
        .AVS_READDATA_OUT(av_rdata), .AVS_WAITREQUEST_OUT(av_wait), .link(link));
    led_seq_device i_led_seq_device (.CLK_IN(clk_in), .RESET_IN(reset_in), .CE_IN(1'b1), .STANDALONE_IN(strap),
        .SENSOR_RED_IN(sns[0]), .SENSOR_GREEN_IN(sns[1]), .SENSOR_BLUE_IN(sns[2]), .MEMORY_PORT_DATA_IN(sda_w),
        .MEMORY_PORT_CLOCK_OUT(scl), .MEMORY_PORT_DATA_OUT(), .MEMORY_PORT_DATA_OE_OUT(sda_oe),
        .RED_LED_DRIVE_OUT(red), .GREEN_LED_DRIVE_OUT(green), .BLUE_LED_DRIVE_OUT(blue),
        .SENSITIVITY_OUT(sens_set), .ANALOG_POWER_DOWN_OUT(apd), .link(link));
    led_seq_link_assertions i_led_seq_link_assertions (.CLK_IN(clk_in), .RESET_IN(reset_in),
        .hw_reset_n(link.hw_reset_n), .sleep(link.sleep), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .cmd_addr(link.cmd_addr), .cmd_wdata(link.cmd_wdata), .cmd_ready(link.cmd_ready),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // The memory line has a pull-up, so the first byte after each start is the address byte.
    always @(negedge sda_w) begin
        if (scl === 1'b1) bitn = 0;
    end
    always @(posedge scl) begin
        if (bitn < 8) begin
            shf = {shf[6:0], sda_w};
            bitn++;
            if (bitn == 8) mem_q.push_back(shf);
        end
    end
    function automatic logic [7:0] ofs_exp(input logic [7:0] c, input logic [11:0] s);
        return c - s[11:4];
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task av(input logic [3:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        av_addr <= a;
        av_write <= wr;
        av_read <= !wr;
        av_wdata <= d;
        do begin
            @(posedge clk_in);
        end while (av_wait !== 1'b0);
        q = av_rdata;
        av_read <= 1'b0;
        av_write <= 1'b0;
    endtask
    task cmd(input cmd_t c, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        logic [31:0] q;
        av(AV_CMD, 1'b1, {17'h0, c, a, d}, q);
        do begin
            av(AV_STATUS, 1'b0, 32'h0, q);
        end while (q[STAT_DONE_BIT] !== 1'b1);
        av(AV_RDATA, 1'b0, 32'h0, q);
        r = q[7:0];
    endtask
    // A span runs from one rising edge of the red drive to the next; the high count is that period's duty.
    task span(output int len, output int hi);
        logic prv;
        len = 0;
        hi = 0;
        do begin
            prv = red;
            @(negedge clk_in);
            len++;
            if (red === 1'b1) hi++;
        end while (!(prv === 1'b0 && red === 1'b1));
    endtask
    task results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (125000) @(posedge clk_in);
        errors++;
        results();
    end
    initial begin
        logic [7:0]  r, d;
        logic [3:0]  a;
        logic [31:0] q;
        int          per, h1, h2, x;
        void'($urandom(32'he00d161a));
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        for (x = 0; x < 8; x++) begin
            a = (x == 0) ? 4'h0 : (x == 7) ? 4'(REG_SENS) : 4'(x + 1);
            d = 8'($urandom);
            cmd(CMD_WRITE, a, d, r);
            cmd(CMD_READ, a, 8'h00, r);
            chk(r, d);
        end
        chk(sens_set, d);
        chk({red, green, blue}, 3'b000);
        for (x = 0; x < 3; x++) begin
            sns[x] <= 12'($urandom);
            cam[x] = 8'($urandom);
            cmd(CMD_WRITE, 4'(REG_CAMERA + x), cam[x], r);
            cmd(CMD_SAMPLE, 4'h0, 8'(x), r);
            cmd(CMD_READ, 4'(REG_SENSOR + x), 8'h00, r);
            chk(r, sns[x][11:4]);
        end
        cmd(CMD_CALC, 4'h0, 8'h00, r);
        for (x = 0; x < 3; x++) begin
            cmd(CMD_READ, 4'(REG_OFFSET + x), 8'h00, r);
            chk(r, ofs_exp(cam[x], sns[x]));
        end
        strap <= 1'b1;
        av(AV_CTRL, 1'b1, 32'h1, q);
        repeat (900) @(negedge clk_in);
        chk(scl, 1'b0);
        av(AV_CTRL, 1'b1, 32'h1, q);
        strap <= 1'b0;
        cmd(CMD_READ, 4'(REG_TARGET), 8'h00, r);
        chk(r, REG_RESET);
        chk({red, green, blue}, 3'b000);
        sns[0] <= 12'h000;
        cmd(CMD_WRITE, 4'(REG_TARGET), 8'hff, r);
        cmd(CMD_RUN, 4'h0, 8'h00, r);
        chk(r[0], 1'b1);
        span(per, h1);
        span(per, h1);
        span(x, h2);
        chk(per, 4096 * (0 + 1));
        chk(h2, h1 + 1);
        av(AV_CTRL, 1'b1, 32'h2, q);
        @(negedge clk_in);
        chk(apd, 1'b1);
        d[0] = red;
        repeat (50) @(negedge clk_in);
        chk(red, d[0]);
        av(AV_CTRL, 1'b1, 32'h0, q);
        cmd(CMD_WRITE, 4'(REG_MODE), 8'h01, r);
        span(per, h1);
        span(per, h1);
        span(x, h2);
        chk(h2, h1);
        sns <= '{12'h000, 12'h000, 12'h000};
        cmd(CMD_SEARCH, 4'h0, 8'h00, r);
        chk(sens_set, SENS_START);
        cmd(CMD_DOWNLOAD, 4'h0, 8'h00, r);
        chk(r[0], 1'b1);
        chk(mem_q[0], MEM_WR_BYTE);
        chk(mem_q[1], MEM_RD_BYTE);
        cmd(CMD_READ, 4'(REG_TARGET), 8'h00, r);
        chk(r, 8'hff);
        results();
    end
endmodule
